// ### quasi_bidir_ports.sv
/*
 * four quasi-bidirectional 8-bit ports with multiplexed external bus on
 * ports 0 and 2 and alternate functions on ports 1 and 3.
 * assumes the core sequences bus phases and strobes; one clock, ref_clk.
 */
// Summary of operation
// - four 8-bit ports, each with latch, driver and input buffer
// - external cycles: port 0 low address with data, port 2 high address
// - write strobe loads latch; latch read and pin read return their values
// - each line works as input or output independently
// - ports 1 and 3 pulled up; latch one releases pull-down for input
// - ports 1 and 3: latch one lets alternate output set the pin
// - ports 0 and 2: latch one disables pull-down for input use
// - port 0 open drain except driving ones during bus cycles
// - bus cycle switches port 0 drivers to address/data, port 2 to high address or its latch
// - ports 0 and 2 unavailable for general i/o during bus use
// - read-modify-write ops read the latch, not the pin
// - bit writes read whole latch, change one bit, write back
// - port 0 drives both levels for address/write data, floats for read
// - port 2 drives both levels while presenting high address
// - program reads use program strobe; data uses read or write strobe
// - instruction fetches use a 16-bit address
// - byte-pointer moves use 8-bit address, data pointer 16-bit
// - port 3 bits 6,7 write/read strobes; bit 0 overcurrent, bit 1 frame
// - port 0 doubles as address/data and keyscan inputs; port 2 keyscan out
// - 16-bit cycle holds high address on port 2, latch untouched
// - 8-bit data cycle keeps port 2 latch on pins
// - every external access writes all ones into port 0 latch
// - address latch strobe marks low address; write data spans write strobe
`timescale 1ns/100ps
module quasi_bidir_ports
(
   input  wire logic                   ref_clk,
   input  wire logic                   nrst,
   input  wire port_pkg::port_req_t    req,
   output      logic [7:0]             rdata,
   input  wire port_pkg::ext_bus_t     ext_bus,
   output      logic [7:0]             ext_rdata,
   output      logic                   addr_latch_strobe,
   output      logic                   program_read_strobe_n,
   input  wire logic [7:0]             alt_out_p1,
   input  wire logic [7:0]             alt_out_p3,
   output      logic [7:0]             keyscan_inputs,
   output      logic [7:0]             alt_in_p1,
   output      logic [7:0]             alt_in_p3,
   output      logic                   overcurrent_sense_n,
   input  wire logic [7:0]             pin_in_p0,
   input  wire logic [7:0]             pin_in_p1,
   input  wire logic [7:0]             pin_in_p2,
   input  wire logic [7:0]             pin_in_p3,
   output      port_pkg::pin_drive_t   drive_p0,
   output      port_pkg::pin_drive_t   drive_p1,
   output      port_pkg::pin_drive_t   drive_p2,
   output      port_pkg::pin_drive_t   drive_p3
);

   // -----------------------------------------------------------------
   // latches and synchronised pins
   // -----------------------------------------------------------------
   logic [7:0] port_latch_reg [port_pkg::NUM_PORTS];
   logic [7:0] pin_synced     [port_pkg::NUM_PORTS];
   logic [7:0] raw_pins       [port_pkg::NUM_PORTS];
   logic       bus_active;
   logic       drive_addr;
   logic       drive_wdata;
   logic [7:0] high_addr_lines;
   logic [7:0] mux_low_addr_data;
   logic [7:0] strobe_bits;

   assign raw_pins[0] = pin_in_p0;
   assign raw_pins[1] = pin_in_p1;
   assign raw_pins[2] = pin_in_p2;
   assign raw_pins[3] = pin_in_p3;

   for (genvar i = 0; i < port_pkg::NUM_PORTS; i++)
   begin : g_sync
      pin_sync #(.WIDTH(port_pkg::PORT_W)) u_sync
      (
         .ref_clk      (ref_clk),
         .nrst         (nrst),
         .pin_in       (raw_pins[i]),
         .pin_sync_out (pin_synced[i])
      );
   end

   // single-bit update of a latched byte
   function automatic logic [7:0] set_bit(input logic [7:0] byte_in, input logic [2:0] sel,
                                          input logic val);
      logic [7:0] result;
      result      = byte_in;
      result[sel] = val;
      return result;
   endfunction

   // -----------------------------------------------------------------
   // bus cycle decode
   // -----------------------------------------------------------------
   assign bus_active  = ext_bus.phase != port_pkg::BUS_IDLE;
   assign drive_addr  = ext_bus.phase == port_pkg::BUS_ADDR;
   assign drive_wdata = ext_bus.phase == port_pkg::BUS_WDATA;

   // code fetches and data-pointer moves place the high byte on port 2
   always_comb
   begin
      unique case (ext_bus.kind)
         port_pkg::KIND_CODE   : high_addr_lines = ext_bus.addr[15:8];
         port_pkg::KIND_DATA16 : high_addr_lines = ext_bus.addr[15:8];
         default               : high_addr_lines = port_latch_reg[2];
      endcase
   end

   assign mux_low_addr_data = drive_addr ? ext_bus.addr[7:0] : ext_bus.wdata;

   // -----------------------------------------------------------------
   // latch writes
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < port_pkg::NUM_PORTS; i++)
            port_latch_reg[i] <= port_pkg::LATCH_RESET;
      end
      else
      begin
         if (req.op == port_pkg::OP_WRITE || req.op == port_pkg::OP_RMW)
            port_latch_reg[req.port] <= req.wdata;
         else if (req.op == port_pkg::OP_BIT_WRITE)
            port_latch_reg[req.port] <= set_bit(port_latch_reg[req.port],
                                                req.bit_sel, req.bit_val);
         if (bus_active)
            port_latch_reg[0] <= port_pkg::BUS_FILL;
      end
   end

   // -----------------------------------------------------------------
   // cpu read data: latch for latch reads and rmw sources, pin for pin reads
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= 8'h00;
      else if (req.op == port_pkg::OP_READ_PIN)
         rdata <= pin_synced[req.port];
      else if (req.op == port_pkg::OP_READ_LATCH || req.op == port_pkg::OP_RMW
               || req.op == port_pkg::OP_BIT_WRITE)
         rdata <= port_latch_reg[req.port];
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         ext_rdata <= 8'h00;
      else if (ext_bus.phase == port_pkg::BUS_RDATA)
         ext_rdata <= pin_synced[0];
   end

   // -----------------------------------------------------------------
   // bus strobes
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         addr_latch_strobe     <= 1'b0;
         program_read_strobe_n <= 1'b1;
         strobe_bits           <= 8'hff;
      end
      else
      begin
         addr_latch_strobe     <= drive_addr;
         program_read_strobe_n <= !(ext_bus.kind == port_pkg::KIND_CODE
                                    && ext_bus.phase == port_pkg::BUS_RDATA);
         strobe_bits           <= 8'hff;
         strobe_bits[port_pkg::P3_WRITE_STRB] <= !(ext_bus.kind != port_pkg::KIND_CODE
                                                  && drive_wdata);
         strobe_bits[port_pkg::P3_READ_STRB]  <= !(ext_bus.kind != port_pkg::KIND_CODE
                                                  && ext_bus.phase == port_pkg::BUS_RDATA);
      end
   end

   // -----------------------------------------------------------------
   // pin drivers
   // -----------------------------------------------------------------
   always_comb
   begin
      // port 0: open drain as gpio, push-pull for address and write data
      if (bus_active)
      begin
         drive_p0.value = mux_low_addr_data;
         drive_p0.oe    = (drive_addr || drive_wdata) ? 8'hff : 8'h00;
      end
      else
      begin
         drive_p0.value = 8'h00;
         drive_p0.oe    = ~port_latch_reg[0];
      end
   end

   always_comb
   begin
      // port 2: strong both levels during bus use
      if (bus_active)
      begin
         drive_p2.value = high_addr_lines;
         drive_p2.oe    = 8'hff;
      end
      else
      begin
         drive_p2.value = 8'h00;
         drive_p2.oe    = ~port_latch_reg[2];
      end
   end

   // ports 1 and 3: pull-down wherever the latch or the alternate output is zero
   always_comb
   begin
      logic [7:0] p3_alt;
      logic [7:0] wr_gate;
      // write strobe drops as soon as port 0 stops carrying write data
      wr_gate = strobe_bits;
      wr_gate[port_pkg::P3_WRITE_STRB] = strobe_bits[port_pkg::P3_WRITE_STRB] | !drive_wdata;
      p3_alt = alt_out_p3 & wr_gate;
      drive_p1.value = 8'h00;
      drive_p1.oe    = ~(port_latch_reg[1] & alt_out_p1);
      drive_p3.value = 8'h00;
      drive_p3.oe    = ~(port_latch_reg[3] & p3_alt);
   end

   // -----------------------------------------------------------------
   // alternate inputs
   // -----------------------------------------------------------------
   assign keyscan_inputs      = pin_synced[0];
   assign alt_in_p1           = pin_synced[1];
   assign alt_in_p3           = pin_synced[3];
   assign overcurrent_sense_n = pin_synced[3][port_pkg::P3_OVERCURRENT];

endmodule // quasi_bidir_ports

// ### port_pkg.sv
/*
 * shared types and constants for the four-port i/o block.
 * assumes a single core clock domain and a cpu core that issues port strobes.
 */
package port_pkg;

   localparam int               PORT_W       = 8;
   localparam int               NUM_PORTS    = 4;
   localparam logic [7:0]       LATCH_RESET  = 8'hff;
   localparam logic [7:0]       BUS_FILL     = 8'hff;
   localparam int               SYNC_STAGES  = 2;

   // port 3 alternate bit positions
   localparam int               P3_OVERCURRENT = 0;
   localparam int               P3_FRAME_START = 1;
   localparam int               P3_WRITE_STRB  = 6;
   localparam int               P3_READ_STRB   = 7;

   // cpu port operations
   typedef enum logic [2:0] {
      OP_NONE      = 3'h0,
      OP_WRITE     = 3'h1,
      OP_READ_PIN  = 3'h3,
      OP_READ_LATCH= 3'h2,
      OP_RMW       = 3'h6,
      OP_BIT_WRITE = 3'h7
   } port_op_t;

   // cpu request to the port block
   typedef struct packed {
      port_op_t   op;
      logic [1:0] port;
      logic [2:0] bit_sel;
      logic       bit_val;
      logic [7:0] wdata;
   } port_req_t;

   // external bus phase requested by the core
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_ADDR  = 2'b01,
      BUS_WDATA = 2'b11,
      BUS_RDATA = 2'b10
   } bus_phase_t;

   typedef enum logic [1:0] {
      KIND_CODE  = 2'h0,
      KIND_DATA8 = 2'h1,
      KIND_DATA16= 2'h2
   } bus_kind_t;

   // external memory cycle control from the core
   typedef struct packed {
      bus_phase_t phase;
      bus_kind_t  kind;
      logic       write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ext_bus_t;

   // pin drive for one port: output value and enable per line
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] oe;
   } pin_drive_t;

endpackage

// ### pin_sync.sv
/*
 * two-stage synchroniser for one port's pins.
 * assumes the pins are asynchronous to ref_clk.
 */
`timescale 1ns/100ps
module pin_sync
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             ref_clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] pin_in,
   output      logic [WIDTH-1:0] pin_sync_out
);

   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         stage_one    <= '1;
         pin_sync_out <= '1;
      end
      else
      begin
         stage_one    <= pin_in;
         pin_sync_out <= stage_one;
      end
   end

endmodule // pin_sync

// ### quasi_bidir_ports_properties.sv
/* concurrent checks on the port block: bus drives, strobes, latch release, sync.
   assumes one ref_clk domain and the bind below. */
`timescale 1ns/100ps
module port_checker
(
   input wire logic                 ref_clk,
   input wire logic                 nrst,
   input wire port_pkg::port_req_t  req,
   input wire port_pkg::ext_bus_t   ext_bus,
   input wire logic                 addr_latch_strobe,
   input wire logic                 program_read_strobe_n,
   input wire logic [7:0]           alt_out_p1,
   input wire logic [7:0]           alt_out_p3,
   input wire logic [7:0]           alt_in_p1,
   input wire logic [7:0]           pin_in_p1,
   input wire port_pkg::pin_drive_t drive_p0,
   input wire port_pkg::pin_drive_t drive_p1,
   input wire port_pkg::pin_drive_t drive_p2,
   input wire port_pkg::pin_drive_t drive_p3
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence bus_busy;
      ext_bus.phase != port_pkg::BUS_IDLE;
   endsequence
   sequence bus_over;
      bus_busy ##1 ext_bus.phase == port_pkg::BUS_IDLE;
   endsequence
   a_ale_after_addr: assert property (ext_bus.phase == port_pkg::BUS_ADDR |=> addr_latch_strobe)
      else $error("address strobe missing");
   a_program_strobe: assert property (ext_bus.phase == port_pkg::BUS_RDATA && ext_bus.kind == port_pkg::KIND_CODE
      |=> !program_read_strobe_n) else $error("program read strobe missing");
   a_p0_addr_drive: assert property (ext_bus.phase == port_pkg::BUS_ADDR
      |-> drive_p0.oe == 8'hff && drive_p0.value == ext_bus.addr[7:0]) else $error("port 0 address wrong");
   a_p2_high_addr: assert property (bus_busy and ext_bus.kind != port_pkg::KIND_DATA8
      |-> drive_p2.oe == 8'hff && drive_p2.value == ext_bus.addr[15:8]) else $error("port 2 address wrong");
   a_p0_write_data: assert property (ext_bus.phase == port_pkg::BUS_WDATA
      |-> drive_p0.oe == 8'hff && drive_p0.value == ext_bus.wdata) else $error("port 0 write data wrong");
   a_p0_read_float: assert property (ext_bus.phase == port_pkg::BUS_RDATA |-> drive_p0.oe == 8'h00)
      else $error("port 0 driven during read");
   a_p0_latch_ones: assert property (bus_over |-> drive_p0.oe == 8'h00)
      else $error("port 0 latch not all ones after bus");
   a_p1_release: assert property (req.op == port_pkg::OP_WRITE && req.port == 2'h1
      |=> drive_p1.oe == ~($past(req.wdata) & alt_out_p1)) else $error("port 1 drive wrong after write");
   a_sync_two_stage: assert property ($past(nrst, 2) |-> alt_in_p1 == $past(pin_in_p1, 2))
      else $error("port 1 input not two stages late");
   a_wr_data_held: assert property (alt_out_p3[port_pkg::P3_WRITE_STRB]
      && drive_p3.oe[port_pkg::P3_WRITE_STRB] |-> ext_bus.phase == port_pkg::BUS_WDATA && drive_p0.oe == 8'hff)
      else $error("write strobe active without port 0 write data");
endmodule // port_checker
bind quasi_bidir_ports port_checker port_checker_i (.ref_clk, .nrst, .req, .ext_bus, .addr_latch_strobe,
   .program_read_strobe_n, .alt_out_p1, .alt_out_p3, .alt_in_p1, .pin_in_p1, .drive_p0, .drive_p1, .drive_p2,
   .drive_p3);

// ### ext_mem_model.sv
/* external memory on the multiplexed bus: latches the address, stores writes, answers reads.
   assumes resolved port 0 and port 2 pin levels and decoded strobes from the bench. */
`timescale 1ns/100ps
module ext_mem_model
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       addr_latch_strobe,
   input  wire logic       program_read_strobe_n,
   input  wire logic       wr_active,
   input  wire logic       rd_active,
   input  wire logic [7:0] pin_p0,
   input  wire logic [7:0] pin_p2,
   output      logic [7:0] bus_val
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr;
   logic [7:0]  pat;
   logic        wr_q;
   logic        ale_q;
   // released bus shows a pattern that changes every cycle
   assign bus_val = (rd_active | ~program_read_strobe_n) ? mem[addr] : pat;
   always @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pat  <= 8'h55;
         wr_q <= 1'b0;
         ale_q <= 1'b0;
      end
      else
      begin
         pat  <= ~pat;
         wr_q <= wr_active;
         ale_q <= addr_latch_strobe;
         // the strobe stays high into the data phase: capture only on its first cycle
         if (addr_latch_strobe & ~ale_q)
            addr <= {pin_p2, pin_p0};
         if (wr_active & ~wr_q)
            mem[addr] <= pin_p0;
      end
   end
endmodule // ext_mem_model

// ### quasi_bidir_ports_tb.sv
/* self-checking bench for the port block with an external memory model.
   assumes the checker is bound from its own file. */
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module quasi_bidir_ports_tb;
   logic                 ref_clk, nrst, addr_latch_strobe, program_read_strobe_n, overcurrent_sense_n;
   port_pkg::port_req_t  req;
   port_pkg::ext_bus_t   ext_bus;
   logic [7:0]           rdata, ext_rdata, keyscan_inputs, alt_in_p1, alt_in_p3, alt_out_p3, p1_low, bus_val;
   logic [7:0]           pin_p0, pin_p1, pin_p2, pin_p3;
   port_pkg::pin_drive_t drive_p0, drive_p1, drive_p2, drive_p3;
   int                   n_mismatch = 0, samples_checked = 0, cycles = 0;
   function automatic logic [7:0] res(port_pkg::pin_drive_t d, logic [7:0] f);
      return (d.oe & d.value) | (~d.oe & f);
   endfunction
   assign pin_p0 = res(drive_p0, bus_val);
   assign pin_p1 = res(drive_p1, ~p1_low);
   assign pin_p2 = res(drive_p2, 8'hff);
   assign pin_p3 = res(drive_p3, 8'hff);
   quasi_bidir_ports quasi_bidir_ports_i (.ref_clk, .nrst, .req, .rdata, .ext_bus, .ext_rdata, .addr_latch_strobe,
      .program_read_strobe_n, .alt_out_p1(8'hff), .alt_out_p3, .keyscan_inputs, .alt_in_p1, .alt_in_p3,
      .overcurrent_sense_n, .pin_in_p0(pin_p0), .pin_in_p1(pin_p1), .pin_in_p2(pin_p2), .pin_in_p3(pin_p3),
      .drive_p0, .drive_p1, .drive_p2, .drive_p3);
   ext_mem_model ext_mem_model_i (.ref_clk, .nrst, .addr_latch_strobe, .program_read_strobe_n,
      .wr_active(drive_p3.oe[6] & ~drive_p3.value[6]), .rd_active(drive_p3.oe[7] & ~drive_p3.value[7]),
      .pin_p0, .pin_p2, .bus_val);
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic step(int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic op(port_pkg::port_op_t o, logic [1:0] p, logic [7:0] d, logic [2:0] b = 3'h0, logic v = 1'b0);
      req = '{o, p, b, v, d};
      step();
      req.op = port_pkg::OP_NONE;
      step();
   endtask
   task automatic bus(port_pkg::bus_kind_t k, logic w, logic [15:0] a, logic [7:0] d);
      ext_bus = '{port_pkg::BUS_ADDR, k, w, a, d};
      step(2);
      ext_bus.phase = w ? port_pkg::BUS_WDATA : port_pkg::BUS_RDATA;
      step(5);
      ext_bus.phase = port_pkg::BUS_IDLE;
      step(2);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      `CHK(drive_p0.oe | drive_p1.oe | drive_p2.oe | drive_p3.oe, 8'h00)
      `CHK(rdata, 8'h00)
   endtask
   task automatic t_gpio();
      op(port_pkg::OP_WRITE, 2'h1, 8'h5a);
      `CHK(drive_p1.oe, 8'ha5)
      `CHK(drive_p1.value & drive_p1.oe, 8'h00)
      p1_low = 8'h02;
      step(3);
      op(port_pkg::OP_READ_PIN, 2'h1, 8'h00);
      `CHK(rdata, 8'h58)
      `CHK(alt_in_p1, 8'h58)
      op(port_pkg::OP_RMW, 2'h1, 8'h5a);
      `CHK(rdata, 8'h5a)
      op(port_pkg::OP_BIT_WRITE, 2'h1, 8'h00, 3'h0, 1'b1);
      op(port_pkg::OP_READ_LATCH, 2'h1, 8'h00);
      `CHK(rdata, 8'h5b)
      alt_out_p3 = 8'hfb;
      step();
      `CHK(drive_p3.oe, 8'h04)
      step(2);
      `CHK(alt_in_p3, 8'hfb)
      `CHK(overcurrent_sense_n, 1'b1)
      alt_out_p3 = 8'hff;
      op(port_pkg::OP_WRITE, 2'h0, 8'h0f);
      `CHK(drive_p0.oe, 8'hf0)
      `CHK(drive_p0.value & drive_p0.oe, 8'h00)
      op(port_pkg::OP_WRITE, 2'h2, 8'h3c);
      `CHK(drive_p2.oe, 8'hc3)
      `CHK(keyscan_inputs & 8'hf0, 8'h00)
   endtask
   task automatic t_bus();
      bus(port_pkg::KIND_DATA16, 1'b1, 16'h1234, 8'ha5);
      `CHK(drive_p2.oe, 8'hc3)
      `CHK(drive_p0.oe, 8'h00)
      `CHK(ext_mem_model_i.mem[16'h1234], 8'ha5)
      bus(port_pkg::KIND_DATA8, 1'b1, 16'h0034, 8'h96);
      `CHK(ext_mem_model_i.addr, 16'h3c34)
      bus(port_pkg::KIND_DATA8, 1'b0, 16'h0034, 8'h00);
      `CHK(ext_rdata, 8'h96)
      bus(port_pkg::KIND_CODE, 1'b0, 16'h1234, 8'h00);
      `CHK(ext_rdata, 8'ha5)
   endtask
   initial
   begin
      nrst = 1'b0;
      req = '0;
      ext_bus = '0;
      alt_out_p3 = 8'hff;
      p1_low = 8'h00;
      repeat (5) @(posedge ref_clk);
      #1 nrst = 1'b1;
      step();
      t_reset();
      t_gpio();
      t_bus();
      stop_test();
   end
endmodule // quasi_bidir_ports_tb
